/* block_power_pkg.sv */
// package for the serial block power control word
// assumes a single 20 MHz system clock domain
package block_power_pkg;

  localparam int unsigned WORD_BITS    = 17;
  localparam int unsigned CNT_W        = 5;
  localparam int unsigned BIT_TX_OSC   = 3;
  localparam int unsigned BIT_TX_MIX   = 4;
  localparam int unsigned BIT_MOD      = 5;
  localparam int unsigned BIT_DRV      = 6;
  localparam int unsigned BIT_DIV2     = 7;
  localparam logic [16:0] CTRL_RESET   = 17'h0_0000;

  // per-block enables, 1 = functional, 0 = standby
  typedef struct packed {
    logic div2_lim;
    logic drv_amp;
    logic modulator;
    logic tx_mixer;
    logic tx_osc;
  } block_en_t;

endpackage

/* serial_power_control_word.sv */
// serial power control word: shift register, holding and operation regs
// assumes serial clock, data and load strobe arrive asynchronously as pins
//
// Contract
// (RULE1) 17 bits, lsb first, into holding register
// (RULE2) strobe rising edge copies holding to operation
// (RULE3) bit 3 enables transmit oscillator and buffer
// (RULE4) bit 4 enables transmit mixer, LO buffer
// (RULE5) bits 5,6,7 enable modulator, driver, divider
// (RULE6) each enable independent; cleared means standby
// (RULE7) reserved bits written zero, ignored by device
`timescale 1ns/1ps
`default_nettype none

module serial_power_control_word
  import block_power_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ser_clk_i,
  input  wire logic        ser_data_i,
  input  wire logic        load_strobe_i,
  output var  block_en_t   block_en_o,
  output var  logic [16:0] op_word_o,
  output var  logic [4:0]  bit_count_o
);

  // ==========================================================
  // input synchronisers
  logic [1:0] sclk_sync_reg;
  logic [1:0] sdat_sync_reg;
  logic [1:0] stb_sync_reg;
  logic       sclk_prev_reg;
  logic       stb_prev_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_sync_reg <= 2'h0;
      sdat_sync_reg <= 2'h0;
      stb_sync_reg  <= 2'h0;
      sclk_prev_reg <= 1'b0;
      stb_prev_reg  <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], ser_clk_i};
      sdat_sync_reg <= {sdat_sync_reg[0], ser_data_i};
      stb_sync_reg  <= {stb_sync_reg[0], load_strobe_i};
      sclk_prev_reg <= sclk_sync_reg[1];
      stb_prev_reg  <= stb_sync_reg[1];
    end
  end

  logic shift_evt;
  logic load_evt;
  assign shift_evt = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign load_evt  = stb_sync_reg[1] & ~stb_prev_reg;

  // ==========================================================
  // holding register, lsb arrives first so shift toward lsb
  logic [16:0] hold_reg;
  logic [4:0]  cnt_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg <= CTRL_RESET;
    end else if (shift_evt) begin
      hold_reg <= {sdat_sync_reg[1], hold_reg[16:1]}; // RULE1
    end
  end

  // bits seen since last load, saturates at word length
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 5'h00;
    end else if (load_evt) begin
      cnt_reg <= 5'h00;
    end else if (shift_evt && cnt_reg != CNT_W'(WORD_BITS)) begin
      cnt_reg <= cnt_reg + 5'h01; // RULE1
    end
  end

  // ==========================================================
  // operation register and block enables
  logic [16:0] op_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg <= CTRL_RESET;
    end else if (load_evt) begin
      op_reg <= hold_reg; // RULE2
    end
  end

  // picks the five enable bits, reserved bits fall away here
  function automatic block_en_t decode_en(input logic [16:0] word);
    block_en_t dec;
    dec.tx_osc    = word[BIT_TX_OSC]; // RULE3
    dec.tx_mixer  = word[BIT_TX_MIX]; // RULE4
    dec.modulator = word[BIT_MOD];    // RULE5
    dec.drv_amp   = word[BIT_DRV];    // RULE5
    dec.div2_lim  = word[BIT_DIV2];   // RULE5
    return dec;
  endfunction

  // reserved bits are stored and reach op_word_o but drive no enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_en_o <= '0;
    end else if (load_evt) begin
      block_en_o <= decode_en(hold_reg); // RULE6
    end
  end

  assign op_word_o   = op_reg;
  assign bit_count_o = cnt_reg;

  // ==========================================================
  // assertions
  load_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |=> op_reg == $past(hold_reg)) // RULE2
    else $error("operation register not loaded from holding");

  hold_stable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !load_evt |=> $stable(op_reg)) // RULE2
    else $error("operation register changed without strobe");

  shift_lsb_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_evt |=> hold_reg[16] == $past(sdat_sync_reg[1])
      && hold_reg[15:0] == $past(hold_reg[16:1])) // RULE1
    else $error("holding register shift wrong");

  osc_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |=> block_en_o.tx_osc == op_reg[3]) // RULE3
    else $error("oscillator enable mismatch");

  mixer_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |=> block_en_o.tx_mixer == op_reg[4]) // RULE4
    else $error("mixer enable mismatch");

  upper_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |=> block_en_o.modulator == op_reg[5]
      && block_en_o.drv_amp == op_reg[6]
      && block_en_o.div2_lim == op_reg[7]) // RULE5
    else $error("modulator driver divider enable mismatch");

  enable_stable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !load_evt |=> $stable(block_en_o)) // RULE6
    else $error("enables changed without strobe");

  count_limit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cnt_reg <= CNT_W'(WORD_BITS)) // RULE1
    else $error("bit count above word length");

  // ==========================================================
  // named steps: pin rise seen by first flop, then edge event
  sequence sclk_seen_s;
    $rose(sclk_sync_reg[0]);
  endsequence

  sequence strobe_seen_s;
    $rose(stb_sync_reg[0]);
  endsequence

  sequence shift_step_s;
    sclk_seen_s ##1 shift_evt;
  endsequence

  sequence load_step_s;
    strobe_seen_s ##1 load_evt;
  endsequence

  sclk_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sclk_seen_s |=> shift_evt) // RULE1
    else $error("serial clock rise not detected");

  strobe_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    strobe_seen_s |=> load_evt) // RULE2
    else $error("strobe rise not detected");

  shift_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_step_s |=> hold_reg[16] == $past(ser_data_i, 3)) // RULE1
    else $error("shifted bit differs from data pin");

  load_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_step_s |=> op_reg == $past(hold_reg) && cnt_reg == 5'h00) // RULE2
    else $error("strobe step did not load word");

  shift_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_evt |-> $past(ser_clk_i, 2)) // RULE1
    else $error("shift without serial clock high");

  load_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |-> $past(load_strobe_i, 2)) // RULE2
    else $error("load without strobe high");

  count_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |=> cnt_reg == 5'h00) // RULE2
    else $error("bit count not cleared by strobe");

  count_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_evt && !load_evt && cnt_reg != CNT_W'(WORD_BITS)
    |=> cnt_reg == $past(cnt_reg) + 5'h01) // RULE1
    else $error("bit count did not step");

  count_sat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    shift_evt && !load_evt && cnt_reg == CNT_W'(WORD_BITS)
    |=> cnt_reg == CNT_W'(WORD_BITS)) // RULE1
    else $error("bit count left saturation");

  count_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !shift_evt && !load_evt |=> $stable(cnt_reg)) // RULE1
    else $error("bit count changed without event");

  hold_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !shift_evt |=> $stable(hold_reg)) // RULE1
    else $error("holding register changed without shift");

  enable_field_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    block_en_o == block_en_t'(op_reg[BIT_DIV2:BIT_TX_OSC])) // RULE6
    else $error("enables differ from operation word");

  enable_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    load_evt |=> op_reg[2:0] == $past(hold_reg[2:0])
      && block_en_o == decode_en($past(hold_reg))) // RULE6
    else $error("load did not copy enables and low bits");

endmodule

`default_nettype wire

/* host_model.sv */
// host model: shifts 17-bit words lsb first, then pulses the strobe
// assumes the bench clock; the device samples through synchronisers
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic clk_i,
  output var  logic sck_o,
  output var  logic sda_o,
  output var  logic stb_o
);
  // ====
  // serial frame and load
  initial {sck_o, sda_o, stb_o} = 3'h0;
  task automatic shift(input logic [16:0] w);
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_i) sda_o <= w[i];
      @(posedge clk_i) sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sck_o <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    sda_o <= ~sda_o;
  endtask
  task automatic load();
    repeat (4) @(posedge clk_i);
    stb_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    stb_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb_serial_power_control_word.sv */
// bench: random and corner control words through the host model
// assumes 20 MHz clock and outputs settled 3 edges after each event
`timescale 1ns/1ps
`default_nettype none
module tb_serial_power_control_word;
  import block_power_pkg::*;
  // ====
  // signals and instances
  logic        clk_i, rst_n_i, sck, sda, stb;
  block_en_t   en;
  logic [16:0] op;
  logic [4:0]  cnt;
  logic [31:0] seed;
  int          n_errors, checked;
  host_model host_model_inst (.clk_i(clk_i), .sck_o(sck), .sda_o(sda),
    .stb_o(stb));
  serial_power_control_word serial_power_control_word_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .ser_clk_i(sck), .ser_data_i(sda),
    .load_strobe_i(stb), .block_en_o(en), .op_word_o(op),
    .bit_count_o(cnt));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [16:0] exp_en(input logic [16:0] w);
    return 17'({w[BIT_DIV2], w[BIT_DRV], w[BIT_MOD], w[BIT_TX_MIX],
      w[BIT_TX_OSC]});
  endfunction
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic run(input logic [16:0] w);
    logic [16:0] old;
    old = op;
    host_model_inst.shift(w);
    repeat (4) @(posedge clk_i);
    chk(op, old);
    chk(17'(cnt), 17'h0_0011);
    host_model_inst.load();
    chk(op, w);
    chk(17'(en), exp_en(w));
    chk(17'(cnt), 17'h0_0000);
  endtask
  // ====
  // clock and main sequence
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    n_errors = 0;
    checked = 0;
    seed = 32'h0000_51e0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk(17'(en), 17'h0_0000);
    for (int b = 3; b < 8; b++) run(17'h0_0001 << b);
    run(17'h0_00f8);
    run(17'h0_0000);
    repeat (8) begin
      seed = lfsr(seed);
      run(seed[16:0] & 17'h0_00f8);
    end
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    chk(op, 17'h0_0000);
    chk(17'(en), 17'h0_0000);
    chk(17'(cnt), 17'h0_0000);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    run(17'h0_0028);
    end_sim();
  end
endmodule
`default_nettype wire
